// ==== common/pll_pkg.sv ====
// Shared constants, field layouts and carrier types for the loop logic
package pll_pkg;

   // Register byte offsets
   localparam logic [3:0] CFG_OFS = 4'h0;
   localparam logic [3:0] REF_RATIO_OFS = 4'h4;
   localparam logic [3:0] FB_RATIO_OFS = 4'h8;
   localparam logic [3:0] STATUS_OFS = 4'hC;

   // Configuration field positions
   localparam int POL_BIT = 7;
   localparam int DSEL_BIT = 6;
   localparam int LDE_BIT = 5;
   localparam int REFSEL_LSB = 2;
   localparam int FVE_BIT = 1;
   localparam int FRE_BIT = 0;

   // Status field positions
   localparam int ST_LAG_BIT = 0;
   localparam int ST_LEAD_BIT = 1;
   localparam int ST_LOCK_BIT = 2;

   localparam int REF_W = 15;
   localparam int FB_W = 16;

   // Values after reset
   localparam logic [7:0] CFG_RST = 8'h10;
   localparam logic [REF_W-1:0] REF_RATIO_RST = 15'h0005;
   localparam logic [FB_W-1:0] FB_RATIO_RST = 16'h0028;

   // Oscillator half-cycles in the reference pulse (4.5 cycles)
   localparam logic [3:0] REF_PULSE_HALVES = 4'h9;

   // Reference output select codes
   localparam logic [2:0] REFSEL_OFF = 3'h0;
   localparam logic [2:0] REFSEL_DIV1 = 3'h1;
   localparam logic [2:0] REFSEL_DIV2 = 3'h2;
   localparam logic [2:0] REFSEL_DIV4 = 3'h3;

   typedef struct packed {
      logic detector_polarity_bit;
      logic dsel;
      logic lde;
      logic [2:0] refsel;
      logic fve;
      logic fre;
   } cfg_s;

   // Detector pin group
   typedef struct packed {
      logic pd_o;
      logic pd_oe;
      logic phi_r_n;
      logic phi_v_n;
      logic lock;
   } det_out_s;

endpackage

// ==== hdl/pll_div_counter.sv ====
// Loadable down counter that ticks once per programmed period
`timescale 1ns/10ps
module pll_div_counter #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Control
   input wire logic i_step,
   input wire logic i_load,
   input wire logic [W-1:0] i_ratio,
   // Period tick
   output logic o_tick
);

   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic tick_r;
   logic tick_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      tick_nxt = 1'b0;
      if (i_load) begin
         cnt_nxt = i_ratio;
      end else if (i_step) begin
         if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
            cnt_nxt = i_ratio;
            tick_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign o_tick = tick_r;

endmodule

// ==== hdl/pll_loop_logic.sv ====
// Dividers, reference output, phase/frequency and lock detectors
//
// The register offsets and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
module pll_loop_logic (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // Avalon-MM slave
   input wire logic [3:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   // Loop pins
   input wire logic i_osc_input,
   input wire logic i_vco_freq_input,
   output logic o_buffered_ref_output,
   output logic o_ref_divider_pulse,
   output logic o_feedback_divider_pulse,
   // Detector pins
   output pll_pkg::det_out_s o_det
);
   import pll_pkg::*;

   // Reset release
   logic [1:0] rst_sync_r;
   logic rst_n;

   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_r[1];

   // Pin synchronisers; stage 1 is read only by stage 2
   logic osc_s1_r;
   logic osc_s2_r;
   logic osc_d_r;
   logic vco_s1_r;
   logic vco_s2_r;
   logic vco_d_r;
   logic osc_rise;
   logic osc_edge;
   logic vco_rise;

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_s1_r <= 1'b0;
         osc_s2_r <= 1'b0;
         osc_d_r <= 1'b0;
         vco_s1_r <= 1'b0;
         vco_s2_r <= 1'b0;
         vco_d_r <= 1'b0;
      end else begin
         osc_s1_r <= i_osc_input;
         osc_s2_r <= osc_s1_r;
         osc_d_r <= osc_s2_r;
         vco_s1_r <= i_vco_freq_input;
         vco_s2_r <= vco_s1_r;
         vco_d_r <= vco_s2_r;
      end
   end

   assign osc_rise = osc_s2_r & ~osc_d_r;
   assign osc_edge = osc_s2_r ^ osc_d_r;
   assign vco_rise = vco_s2_r & ~vco_d_r;

   // Register file
   cfg_s cfg_r;
   cfg_s cfg_nxt;
   logic [REF_W-1:0] ref_ratio_r;
   logic [REF_W-1:0] ref_ratio_nxt;
   logic [FB_W-1:0] fb_ratio_r;
   logic [FB_W-1:0] fb_ratio_nxt;
   logic ack_r;
   logic ack_nxt;
   logic wait_r;
   logic wait_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic jam_r;
   logic jam_nxt;
   logic [2:0] status;
   logic wr_take;

   // One wait cycle: request seen, then answered on the next edge
   assign wr_take = i_write & ack_r;

   always_comb begin
      cfg_nxt = cfg_r;
      ref_ratio_nxt = ref_ratio_r;
      fb_ratio_nxt = fb_ratio_r;
      jam_nxt = 1'b0;
      ack_nxt = (i_read | i_write) & ~ack_r;
      wait_nxt = ~ack_nxt;
      rdata_nxt = rdata_r;
      if (i_read & ~ack_r) begin
         case (i_address)
            CFG_OFS: rdata_nxt = {24'h000000, cfg_r};
            REF_RATIO_OFS: rdata_nxt = {17'h0, ref_ratio_r};
            FB_RATIO_OFS: rdata_nxt = {16'h0000, fb_ratio_r};
            STATUS_OFS: rdata_nxt = {29'h0, status};
            default: rdata_nxt = 32'h00000000;
         endcase
      end
      if (wr_take) begin
         case (i_address)
            CFG_OFS: begin
               if (i_byteenable[0]) begin
                  cfg_nxt = cfg_s'(i_writedata[7:0]);
               end
            end
            REF_RATIO_OFS: begin
               if (i_byteenable[0]) begin
                  ref_ratio_nxt[7:0] = i_writedata[7:0];
               end
               if (i_byteenable[1]) begin
                  ref_ratio_nxt[14:8] = i_writedata[14:8];
               end
            end
            FB_RATIO_OFS: begin
               if (i_byteenable[0]) begin
                  fb_ratio_nxt[7:0] = i_writedata[7:0];
               end
               if (i_byteenable[1]) begin
                  fb_ratio_nxt[15:8] = i_writedata[15:8];
               end
               jam_nxt = |i_byteenable[1:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r <= cfg_s'(CFG_RST);
         ref_ratio_r <= REF_RATIO_RST;
         fb_ratio_r <= FB_RATIO_RST;
         jam_r <= 1'b0;
         ack_r <= 1'b0;
         wait_r <= 1'b1;
         rdata_r <= 32'h00000000;
      end else begin
         cfg_r <= cfg_nxt;
         ref_ratio_r <= ref_ratio_nxt;
         fb_ratio_r <= fb_ratio_nxt;
         jam_r <= jam_nxt;
         ack_r <= ack_nxt;
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign o_readdata = rdata_r;
   // Own flop, so the bus never sees a gate after the register
   assign o_waitrequest = wait_r;

   // Dividers
   logic ref_bypass;
   logic ref_tick;
   logic fb_tick;

   assign ref_bypass = (ref_ratio_r == {{(REF_W-1){1'b0}}, 1'b1});

   pll_div_counter #(
      .W(REF_W)
   ) u_ref_div (
      .i_core_clk(i_core_clk),
      .i_rst_n(rst_n),
      .i_step(osc_rise),
      .i_load(jam_r),
      .i_ratio(ref_ratio_r),
      .o_tick(ref_tick)
   );

   pll_div_counter #(
      .W(FB_W)
   ) u_fb_div (
      .i_core_clk(i_core_clk),
      .i_rst_n(rst_n),
      .i_step(vco_rise),
      .i_load(jam_r),
      .i_ratio(fb_ratio_r),
      .o_tick(fb_tick)
   );

   // Comparison events; bypass feeds oscillator edges straight through
   logic ref_evt;
   logic fb_evt;

   assign ref_evt = ref_bypass ? osc_rise : ref_tick;
   assign fb_evt = fb_tick;

   // Divider pulse shaping
   logic ref_hi_r;
   logic ref_hi_nxt;
   logic [3:0] ref_half_r;
   logic [3:0] ref_half_nxt;
   logic fb_hi_r;
   logic fb_hi_nxt;
   logic fr_pin_r;
   logic fr_pin_nxt;
   logic fv_pin_r;
   logic fv_pin_nxt;

   always_comb begin
      ref_hi_nxt = ref_hi_r;
      ref_half_nxt = ref_half_r;
      fb_hi_nxt = fb_hi_r;
      if (jam_r) begin
         ref_hi_nxt = 1'b0;
         ref_half_nxt = 4'h0;
         fb_hi_nxt = 1'b0;
      end else begin
         // Pulse counts oscillator half-cycles, so it ends on a fall
         if (ref_tick) begin
            ref_hi_nxt = 1'b1;
            ref_half_nxt = REF_PULSE_HALVES;
         end else if (osc_edge && ref_half_r != 4'h0) begin
            ref_half_nxt = ref_half_r - 4'h1;
            if (ref_half_r == 4'h1) begin
               ref_hi_nxt = 1'b0;
            end
         end
         // Feedback pulse lasts one VCO period
         if (fb_tick) begin
            fb_hi_nxt = 1'b1;
         end else if (vco_rise) begin
            fb_hi_nxt = 1'b0;
         end
      end
      if (!cfg_r.fre) begin
         fr_pin_nxt = 1'b0;
      end else if (ref_bypass) begin
         fr_pin_nxt = osc_s2_r;
      end else begin
         fr_pin_nxt = ref_hi_r;
      end
      fv_pin_nxt = cfg_r.fve & fb_hi_r;
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_hi_r <= 1'b0;
         ref_half_r <= 4'h0;
         fb_hi_r <= 1'b0;
         fr_pin_r <= 1'b0;
         fv_pin_r <= 1'b0;
      end else begin
         ref_hi_r <= ref_hi_nxt;
         ref_half_r <= ref_half_nxt;
         fb_hi_r <= fb_hi_nxt;
         fr_pin_r <= fr_pin_nxt;
         fv_pin_r <= fv_pin_nxt;
      end
   end

   assign o_ref_divider_pulse = fr_pin_r;
   assign o_feedback_divider_pulse = fv_pin_r;

   // Buffered reference output prescaler
   logic [3:0] pre_r;
   logic [3:0] pre_nxt;
   logic buffered_ref_output_r;
   logic buffered_ref_output_nxt;

   always_comb begin
      pre_nxt = osc_rise ? pre_r + 4'h1 : pre_r;
      case (cfg_r.refsel)
         REFSEL_OFF: buffered_ref_output_nxt = 1'b0;
         REFSEL_DIV1: buffered_ref_output_nxt = osc_s2_r;
         REFSEL_DIV2: buffered_ref_output_nxt = pre_r[0];
         REFSEL_DIV4: buffered_ref_output_nxt = pre_r[1];
         default: buffered_ref_output_nxt = cfg_r.refsel[0] ? pre_r[3] : pre_r[2];
      endcase
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_r <= 4'h0;
         buffered_ref_output_r <= 1'b0;
      end else begin
         pre_r <= pre_nxt;
         buffered_ref_output_r <= buffered_ref_output_nxt;
      end
   end

   assign o_buffered_ref_output = buffered_ref_output_r;

   // Phase/frequency detector: lag = reference first, lead = feedback
   logic lag_r;
   logic lag_nxt;
   logic lead_r;
   logic lead_nxt;
   det_out_s det_r;
   det_out_s det_nxt;
   logic sink;
   logic source;

   always_comb begin
      lag_nxt = lag_r;
      lead_nxt = lead_r;
      if (jam_r) begin
         lag_nxt = 1'b0;
         lead_nxt = 1'b0;
      end else if (lag_r & lead_r) begin
         // Both set for one cycle: the short coincident pulse
         lag_nxt = ref_evt;
         lead_nxt = fb_evt;
      end else begin
         lag_nxt = lag_r | ref_evt;
         lead_nxt = lead_r | fb_evt;
      end
   end

   always_comb begin
      // Matched edges set both lag and lead but turn neither driver on; leave the pin floating then
      sink = cfg_r.detector_polarity_bit ? lag_r & ~lead_r : lead_r & ~lag_r;
      source = cfg_r.detector_polarity_bit ? lead_r & ~lag_r : lag_r & ~lead_r;
      det_nxt.pd_o = source;
      det_nxt.pd_oe = cfg_r.dsel & (sink | source);
      if (!cfg_r.dsel) begin
         det_nxt.phi_v_n = ~(cfg_r.detector_polarity_bit ? lag_r : lead_r);
         det_nxt.phi_r_n = ~(cfg_r.detector_polarity_bit ? lead_r : lag_r);
      end else begin
         det_nxt.phi_v_n = 1'b1;
         det_nxt.phi_r_n = 1'b1;
      end
      det_nxt.lock = cfg_r.lde & ~(lag_r | lead_r);
   end

   always_ff @(posedge i_core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lag_r <= 1'b0;
         lead_r <= 1'b0;
         det_r <= '{pd_o: 1'b0, pd_oe: 1'b0, phi_r_n: 1'b1,
                    phi_v_n: 1'b1, lock: 1'b0};
      end else begin
         lag_r <= lag_nxt;
         lead_r <= lead_nxt;
         det_r <= det_nxt;
      end
   end

   assign o_det = det_r;

   // Status: live detector state for software
   assign status[ST_LAG_BIT] = lag_r;
   assign status[ST_LEAD_BIT] = lead_r;
   assign status[ST_LOCK_BIT] = det_r.lock;

endmodule

// ==== tb/loop_logic_sva.sv ====
// Port checker for the loop logic, bound to its top module
`timescale 1ns/10ps
module loop_logic_sva
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // Register bus
   input wire logic [3:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0] i_byteenable,
   input wire logic [31:0] o_readdata,
   input wire logic o_waitrequest,
   // Loop pins
   input wire logic i_osc_input,
   input wire logic i_vco_freq_input,
   input wire logic o_buffered_ref_output,
   input wire logic o_ref_divider_pulse,
   input wire logic o_feedback_divider_pulse,
   input wire pll_pkg::det_out_s o_det
);
   import pll_pkg::*;
   logic [7:0] cfg_r;
   logic ref_one_r;
   logic osc_q;
   logic [6:0] stab_r;
   logic [4:0] tog_r;
   wire wr_done = i_write && !o_waitrequest && i_byteenable[0];
   // Gates are judged only once any write on byte lane 0 has settled
   wire ok = stab_r > 7'h07;
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cfg_r <= CFG_RST;
         ref_one_r <= 1'b0;
         stab_r <= 7'h00;
      end else begin
         if (wr_done && i_address == CFG_OFS)
            cfg_r <= i_writedata[7:0];
         if (wr_done && i_address == REF_RATIO_OFS)
            ref_one_r <= i_writedata[14:0] == 15'h0001;
         stab_r <= wr_done ? 7'h00 : stab_r + 7'(stab_r != 7'h7F);
      end
   end
   // Oscillator transitions seen while the reference pulse is high
   always_ff @(posedge i_core_clk) begin
      osc_q <= i_osc_input;
      if (!o_ref_divider_pulse)
         tog_r <= 5'h00;
      else if (osc_q != i_osc_input)
         tog_r <= tog_r + 5'h01;
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   ans_next_a: assert property ((i_read || i_write) && o_waitrequest
      |=> !o_waitrequest) else $error("bus request not answered");
   ans_once_a: assert property (!o_waitrequest |=> o_waitrequest)
      else $error("waitrequest low too long");
   ref_gate_a: assert property (ok && !cfg_r[FRE_BIT]
      |-> !o_ref_divider_pulse) else $error("reference pulse not gated");
   fb_gate_a: assert property (ok && !cfg_r[FVE_BIT]
      |-> !o_feedback_divider_pulse) else $error("feedback pulse not gated");
   lock_gate_a: assert property (ok && !cfg_r[LDE_BIT]
      |-> !o_det.lock) else $error("lock output not gated");
   pd_float_a: assert property (ok && !cfg_r[DSEL_BIT]
      |-> !o_det.pd_oe) else $error("single-ended output driven");
   dbl_idle_a: assert property (ok && cfg_r[DSEL_BIT]
      |-> o_det.phi_r_n && o_det.phi_v_n) else $error("double pair not high");
   buffered_ref_output_off_a: assert property (ok && cfg_r[4:2] == REFSEL_OFF
      |-> !o_buffered_ref_output) else $error("reference output not low");
   pulse_width_a: assert property ($fell(o_ref_divider_pulse)
      && !ref_one_r && stab_r == 7'h7F |-> tog_r == 5'h09)
      else $error("reference pulse width wrong");
endmodule
bind pll_loop_logic loop_logic_sva loop_logic_sva_i (
   .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_address(i_address),
   .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
   .i_byteenable(i_byteenable), .o_readdata(o_readdata),
   .o_waitrequest(o_waitrequest), .i_osc_input(i_osc_input),
   .i_vco_freq_input(i_vco_freq_input),
   .o_buffered_ref_output(o_buffered_ref_output),
   .o_ref_divider_pulse(o_ref_divider_pulse),
   .o_feedback_divider_pulse(o_feedback_divider_pulse), .o_det(o_det));

// ==== tb/osc_vco_model.sv ====
// Free-running oscillator and VCO pin model
`timescale 1ns/10ps
module osc_vco_model (
   // Clock
   input wire logic i_core_clk,
   // Half periods in core clocks
   input wire logic [7:0] i_osc_half,
   input wire logic [7:0] i_vco_half,
   // Pins
   output logic o_osc = 1'b0,
   output logic o_vco = 1'b0
);
   logic [7:0] oc_r = 8'h00;
   logic [7:0] vc_r = 8'h00;
   // Half periods of seven clocks or more keep divider outputs slow
   always_ff @(posedge i_core_clk) begin
      oc_r <= (oc_r + 8'h01 >= i_osc_half) ? 8'h00 : oc_r + 8'h01;
      vc_r <= (vc_r + 8'h01 >= i_vco_half) ? 8'h00 : vc_r + 8'h01;
      if (oc_r + 8'h01 >= i_osc_half)
         o_osc <= !o_osc;
      if (vc_r + 8'h01 >= i_vco_half)
         o_vco <= !o_vco;
   end
endmodule

// ==== tb/tb.sv ====
// Testbench for the loop logic: registers, dividers and detectors
`timescale 1ns/10ps
module tb;
   import pll_pkg::*;
   logic clk = 1'b0;
   logic i_nrst = 1'b0;
   logic [3:0] i_address = 4'h0;
   logic i_read = 1'b0;
   logic i_write = 1'b0;
   logic [31:0] i_writedata = 32'h0;
   logic [31:0] o_readdata;
   logic [31:0] rd;
   logic o_waitrequest, osc, vco, ref_out, fr, fv;
   logic [7:0] osc_half = 8'h07;
   logic [3:0] be = 4'hF;
   det_out_s det;
   int err_count = 0;
   int n_compared = 0;
   always #4 clk = ~clk;
   osc_vco_model osc_vco_model_i (.i_core_clk(clk), .i_osc_half(osc_half),
      .i_vco_half(8'h04), .o_osc(osc), .o_vco(vco));
   pll_loop_logic pll_loop_logic_i (.i_core_clk(clk), .i_nrst(i_nrst),
      .i_address(i_address), .i_read(i_read), .i_write(i_write),
      .i_writedata(i_writedata), .i_byteenable(be),
      .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
      .i_osc_input(osc), .i_vco_freq_input(vco),
      .o_buffered_ref_output(ref_out), .o_ref_divider_pulse(fr),
      .o_feedback_divider_pulse(fv), .o_det(det));
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         err_count++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   task automatic hang(input string nm);
      err_count++;
      $display("[ERR] %s expected done seen timeout", nm);
      stop_test();
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input int d);
      int n;
      n = 0;
      i_address <= a;
      i_write <= w;
      i_read <= !w;
      i_writedata <= d;
      do begin
         @(posedge clk);
         n++;
         if (n > 20) hang("bus");
      end while (o_waitrequest !== 1'b0);
      rd = o_readdata;
      i_read <= 1'b0;
      i_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rchk(input string nm, input logic [3:0] a, input int e);
      bus(1'b0, a, 0);
      chk(nm, rd, e);
   endtask
   // Input rises counted between two rises of the chosen output
   task automatic per(input int s, input int e);
      int n, k;
      logic p, ps, c, cs;
      n = 0;
      k = -1;
      ps = 1'b1;
      cs = 1'b1;
      for (int t = 0; t < 6000 && k < 1; t++) begin
         @(posedge clk);
         p = (s == 0) ? ref_out : (s == 1) ? fr : fv;
         c = (s == 2) ? vco : osc;
         if (c && !cs) n++;
         if (p && !ps) begin
            k++;
            if (k == 0) n = 0;
         end
         ps = p;
         cs = c;
      end
      if (k < 1) hang("period");
      chk("period", n, e);
   endtask
   task automatic t_reset;
      rchk("cfg", CFG_OFS, CFG_RST);
      rchk("ref ratio", REF_RATIO_OFS, REF_RATIO_RST);
      rchk("fb ratio", FB_RATIO_OFS, FB_RATIO_RST);
      bus(1'b0, STATUS_OFS, 0);
      chk("lock", rd[ST_LOCK_BIT], 1'b0);
      bus(1'b1, 4'h2, 32'hFF);
      rchk("hole", 4'h2, 0);
      rchk("cfg kept", CFG_OFS, CFG_RST);
      be <= 4'h2;
      bus(1'b1, REF_RATIO_OFS, 32'h7F00);
      be <= 4'hF;
      rchk("lane", REF_RATIO_OFS, 32'h7F05);
      per(0, 8);
   endtask
   task automatic t_refsel;
      int tbl[8] = '{0, 1, 2, 4, 8, 16, 8, 16};
      for (int c = 1; c < 8; c++) begin
         bus(1'b1, CFG_OFS, c << 2);
         per(0, tbl[c]);
      end
      bus(1'b1, CFG_OFS, 0);
      repeat (100) @(posedge clk);
      chk("ref off", ref_out, 1'b0);
   endtask
   task automatic t_div;
      int r[3] = '{7, 5, 1};
      bus(1'b1, CFG_OFS, 32'h13);
      for (int i = 0; i < 3; i++) begin
         // Bypass passes the raw oscillator, so slow it down
         osc_half <= (r[i] == 1) ? 8'h28 : 8'h07;
         bus(1'b1, REF_RATIO_OFS, r[i]);
         bus(1'b1, FB_RATIO_OFS, 40);
         repeat (200) @(posedge clk);
         per(1, r[i]);
      end
      osc_half <= 8'h07;
      per(2, 40);
      bus(1'b1, FB_RATIO_OFS, 41);
      per(2, 41);
   endtask
   task automatic t_det(input logic detector_polarity_bit, dsel, lead);
      logic sv, sr, sk, ss, sl, sb, sh, x;
      {sv, sr, sk, ss, sl, sb, sh} = 7'h00;
      x = lead ^ detector_polarity_bit;
      osc_half <= lead ? 8'h28 : 8'h07;
      bus(1'b1, CFG_OFS, {detector_polarity_bit, dsel, 6'b110000});
      bus(1'b1, REF_RATIO_OFS, 5);
      bus(1'b1, FB_RATIO_OFS, 40);
      bus(1'b0, STATUS_OFS, 0);
      chk("flags", rd[1:0], 2'b00);
      repeat (300) @(posedge clk);
      for (int i = 0; i < 3000; i++) begin
         @(posedge clk);
         sv |= det.phi_v_n === 1'b0 && det.phi_r_n === 1'b1;
         sr |= det.phi_r_n === 1'b0 && det.phi_v_n === 1'b1;
         sk |= det.pd_oe === 1'b1 && det.pd_o === 1'b0;
         ss |= det.pd_oe === 1'b1 && det.pd_o === 1'b1;
         sl |= det.lock === 1'b0;
         sb |= det.phi_r_n === 1'b0 && det.phi_v_n === 1'b0;
         sh |= det.lock === 1'b1;
      end
      chk("v side", sv, !dsel && x);
      chk("r side", sr, !dsel && !x);
      chk("pd sink", sk, dsel && x);
      chk("pd source", ss, dsel && !x);
      chk("lock low", sl, 1'b1);
      chk("both low", sb, !dsel);
      chk("lock high", sh, 1'b1);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      i_nrst <= 1'b1;
      repeat (4) @(posedge clk);
      t_reset();
      t_refsel();
      t_div();
      for (int k = 0; k < 8; k++)
         t_det(k[0], k[1], k[2]);
      stop_test();
   end
endmodule
